// [pkg/sacl_regs.vh]
`ifndef SACL_REGS_VH
`define SACL_REGS_VH

// ==========================================================
// register offsets
`define SACL_ADDR_ALT_SEL 8'h4f
`define SACL_ADDR_CTL 8'h5f
`define SACL_ADDR_TX_LO 8'h60
`define SACL_ADDR_TX_HI 8'h61
`define SACL_ADDR_RX_LO 8'h62
`define SACL_ADDR_RX_HI 8'h63
`define SACL_ADDR_RAW 8'hf9
`define SACL_ADDR_STAT 8'hfb
`define SACL_ADDR_MASK 8'hfd
`define SACL_ADDR_CLR 8'hff

// ==========================================================
// control and status fields
`define SACL_CTL_PIN_MODE 0
`define SACL_CTL_SEL 2
`define SACL_CTL_GO 3
`define SACL_CTL_AUTO_RX 4
`define SACL_CTL_RX_ERR 5
`define SACL_ALT_ANT_IN 0

// ==========================================================
// event flag positions
`define SACL_EV_TIMEOUT 3
`define SACL_EV_TX_DONE 4
`define SACL_EV_RX_DONE 5
`define SACL_EV_ALL 8'h38

// ==========================================================
// reset values
`define SACL_RST_BYTE 8'h00

// ==========================================================
// word lengths
`define SACL_TX_BITS 14
`define SACL_RX_BITS 10

// ==========================================================
// timing
`define SACL_CLK_NS 10
`define SACL_REPLY_TIMEOUT_NS 100000000
`define SACL_REPLY_TIMEOUT_CYC (`SACL_REPLY_TIMEOUT_NS / `SACL_CLK_NS)
`define SACL_SLICE_NS 250000
`define SACL_SLICE_CYC (`SACL_SLICE_NS / `SACL_CLK_NS)
`define SACL_BIT_SLICES 4
`define SACL_ZERO_HI_SLICES 1
`define SACL_ONE_HI_SLICES 3

`endif

// [hdl/sacl_top.v]
`timescale 1ns/1ns
`include "sacl_regs.vh"

// Behaviour
// R1: basic mode transmits only; advanced mode also receives replies.
// R2: control bit 0 picks shared line or separate input line.
// R3: direction output low while receiving, high while driving the shared line.
// R4: receive-complete flag sets when a reply word is fully taken.
// R5: transmit-complete flag sets when the outgoing word ends.
// R6: timeout flag sets on no reply or an incomplete reply.
// R7: receive-error bit sets when a reply ends incomplete.
// R8: interrupt request rises for enabled, set event flags.
// R9: host not using interrupt masks events and polls flags.
// R10: host interrogates with a basic word whose channel field is zero.
// R11: after sending, release the line and wait up to 100 ms.
// R12: advanced antenna answers with a 10-bit identifier.
// R13: host sets transaction select and auto-receive before transmitting.
// R14: host loads the 14-bit word into two transmit registers.
// R15: writing transmit-start begins sending the loaded word.
// R16: host clears transaction select, keeps auto-receive, to receive.
// R17: received 10-bit value lands in two receive registers.
// R18: no reply within 100 ms after transmit gives receive timeout.
// R19: host treats nonzero error-free data as advanced reply, zero as basic.
// R20: separate input shares general pin 0, chosen by alternate select.
// R21: all general pins come up as inputs.
// R22: line words use pulse-width bits, most significant first.
module sacl_top #(
    parameter integer REPLY_CYC = `SACL_REPLY_TIMEOUT_CYC,
    parameter integer SLICE_CYC = `SACL_SLICE_CYC,
    parameter integer BIT_SLICES = `SACL_BIT_SLICES,
    parameter integer ZERO_HI = `SACL_ZERO_HI_SLICES,
    parameter integer ONE_HI = `SACL_ONE_HI_SLICES
) (
    // clock and reset
    input wire REF_CLK,
    input wire RESETN,
    // register port
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    // antenna line
    input wire ANTENNA_LINE_IO_I,
    output reg ANTENNA_LINE_IO_O,
    output reg ANTENNA_LINE_IO_OE_N,
    output reg ANTENNA_DIRECTION_OUT,
    output reg ANTENNA_DIRECTION_OUT_OE_N,
    input wire ANTENNA_SEPARATE_INPUT,
    // interrupt
    output reg INTERRUPT_REQUEST_OUT
);

    // ==========================================================
    // states
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_TX = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_RX = 4'b1000;

    function wr_hit;
        input [7:0] a;
        input [7:0] off;
        begin
            wr_hit = REG_WR && (a == off);
        end
    endfunction

    // ==========================================================
    // registers
    reg [7:0] alt_sel_q;
    reg pin_mode_q;
    reg sel_q;
    reg auto_rx_q;
    reg rx_err_q;
    reg [7:0] tx_lo_q;
    reg [5:0] tx_hi_q;
    reg [7:0] rx_lo_q;
    reg [1:0] rx_hi_q;
    reg [7:0] raw_q;
    reg [7:0] mask_q;
    reg [3:0] st_q;
    reg [3:0] st_d;
    reg [31:0] slice_cnt_q;
    reg [7:0] slice_idx_q;
    reg [4:0] bit_idx_q;
    reg [31:0] wait_cnt_q;
    reg [31:0] hi_cnt_q;
    reg [9:0] rx_shift_q;
    reg rx_prev_q;

    wire two_pin = pin_mode_q;
    wire slice_tick = (slice_cnt_q == SLICE_CYC - 1);
    wire bit_end = slice_tick && (slice_idx_q == BIT_SLICES - 1);
    wire [13:0] tx_word = {tx_hi_q, tx_lo_q};
    // second pin only serves the antenna once selected away from gpio use
    wire rx_in = (two_pin && alt_sel_q[`SACL_ALT_ANT_IN]) ? ANTENNA_SEPARATE_INPUT
                                                           : ANTENNA_LINE_IO_I; // [R2] [R20]
    wire rx_rise = rx_in && !rx_prev_q;
    wire rx_fall = !rx_in && rx_prev_q;
    // next-cycle pulse shape, so the line opens high on the edge that enables it
    wire [7:0] slice_idx_nx = (st_q != ST_TX || bit_end) ? 8'h00
                              : (slice_tick ? slice_idx_q + 8'h01 : slice_idx_q);
    wire [4:0] bit_idx_nx = (st_q != ST_TX) ? 5'd13
                            : ((bit_end && bit_idx_q != 5'd0) ? bit_idx_q - 5'd1 : bit_idx_q);
    wire [7:0] hi_slices = tx_word[bit_idx_nx[3:0]] ? ONE_HI[7:0] : ZERO_HI[7:0];
    wire go_wr = wr_hit(REG_ADDR, `SACL_ADDR_CTL) && REG_WDATA[`SACL_CTL_GO];
    wire rx_arm_wr = wr_hit(REG_ADDR, `SACL_ADDR_CTL) && !REG_WDATA[`SACL_CTL_GO]
                     && !REG_WDATA[`SACL_CTL_SEL] && REG_WDATA[`SACL_CTL_AUTO_RX];
    // a reply bit longer than two bit periods counts as a broken word
    wire rx_stall = (hi_cnt_q >= 2 * BIT_SLICES * SLICE_CYC);
    wire rx_bit = (hi_cnt_q >= ((ZERO_HI + ONE_HI) * SLICE_CYC) / 2);

    reg ev_tx_done;
    reg ev_rx_done;
    reg ev_timeout;
    reg ev_rx_err;

    // ==========================================================
    // sequencer
    always @*
    begin
        st_d = st_q;
        ev_tx_done = 1'b0;
        ev_rx_done = 1'b0;
        ev_timeout = 1'b0;
        ev_rx_err = 1'b0;
        case (st_q)
            ST_IDLE:
            begin
                if (go_wr)
                    st_d = ST_TX; // [R15]
                else if (rx_arm_wr)
                    st_d = ST_WAIT; // [R1]
            end
            ST_TX:
            begin
                if (bit_end && bit_idx_q == 5'd0)
                begin
                    ev_tx_done = 1'b1; // [R5]
                    // basic mode stops after sending
                    st_d = auto_rx_q ? ST_WAIT : ST_IDLE; // [R1] [R11]
                end
            end
            ST_WAIT:
            begin
                if (rx_rise)
                    st_d = ST_RX;
                else if (wait_cnt_q == REPLY_CYC - 1)
                begin
                    ev_timeout = 1'b1; // [R11] [R18] [R6]
                    st_d = ST_IDLE;
                end
            end
            ST_RX:
            begin
                if (rx_fall && bit_idx_q == `SACL_RX_BITS - 1)
                begin
                    ev_rx_done = 1'b1; // [R4]
                    st_d = ST_IDLE;
                end
                else if (rx_stall)
                begin
                    ev_timeout = 1'b1; // [R6]
                    ev_rx_err = 1'b1; // [R7]
                    st_d = ST_IDLE;
                end
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
            st_q <= ST_IDLE;
        else
            st_q <= st_d;
    end

    // ==========================================================
    // bit timing
    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            slice_cnt_q <= 32'h0;
            slice_idx_q <= 8'h00;
            bit_idx_q <= 5'h00;
            wait_cnt_q <= 32'h0;
            hi_cnt_q <= 32'h0;
            rx_shift_q <= 10'h000;
            rx_prev_q <= 1'b0;
        end
        else
        begin
            rx_prev_q <= rx_in;
            if (st_q == ST_IDLE && st_d == ST_TX)
            begin
                slice_cnt_q <= 32'h0;
                slice_idx_q <= 8'h00;
                bit_idx_q <= 5'd13; // [R22]
            end
            else if (st_q == ST_TX)
            begin
                slice_cnt_q <= slice_tick ? 32'h0 : slice_cnt_q + 32'h1;
                if (slice_tick)
                    slice_idx_q <= (slice_idx_q == BIT_SLICES - 1) ? 8'h00 : slice_idx_q + 8'h01;
                if (bit_end && bit_idx_q != 5'd0)
                    bit_idx_q <= bit_idx_q - 5'd1; // [R22]
            end
            if (st_q != ST_WAIT)
                wait_cnt_q <= 32'h0;
            else
                wait_cnt_q <= wait_cnt_q + 32'h1; // [R18]
            // first reply edge restarts the bit count
            if (st_q == ST_WAIT && rx_rise)
            begin
                bit_idx_q <= 5'd0;
                hi_cnt_q <= 32'h0;
            end
            else if (st_q == ST_RX)
            begin
                if (rx_rise || rx_fall)
                    hi_cnt_q <= 32'h0;
                else
                    hi_cnt_q <= hi_cnt_q + 32'h1;
                if (rx_fall)
                begin
                    rx_shift_q <= {rx_shift_q[8:0], rx_bit}; // [R22]
                    bit_idx_q <= bit_idx_q + 5'd1;
                end
            end
        end
    end

    // ==========================================================
    // pins
    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ANTENNA_LINE_IO_O <= 1'b0;
            ANTENNA_LINE_IO_OE_N <= 1'b1; // [R21]
            ANTENNA_DIRECTION_OUT <= 1'b0;
            ANTENNA_DIRECTION_OUT_OE_N <= 1'b1; // [R21]
        end
        else
        begin
            // line is released outside sending so the antenna can answer
            ANTENNA_LINE_IO_OE_N <= (st_d != ST_TX); // [R11]
            ANTENNA_LINE_IO_O <= (st_d == ST_TX) && (slice_idx_nx < hi_slices); // [R22]
            ANTENNA_DIRECTION_OUT <= (st_d == ST_TX); // [R3]
            ANTENNA_DIRECTION_OUT_OE_N <= !(auto_rx_q && !two_pin); // [R3] [R21]
        end
    end

    // ==========================================================
    // register file
    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            alt_sel_q <= `SACL_RST_BYTE;
            pin_mode_q <= 1'b0;
            sel_q <= 1'b0;
            auto_rx_q <= 1'b0;
            rx_err_q <= 1'b0;
            tx_lo_q <= `SACL_RST_BYTE;
            tx_hi_q <= 6'h00;
            rx_lo_q <= `SACL_RST_BYTE;
            rx_hi_q <= 2'h0;
            raw_q <= `SACL_RST_BYTE;
            mask_q <= `SACL_RST_BYTE;
        end
        else
        begin
            if (wr_hit(REG_ADDR, `SACL_ADDR_ALT_SEL))
                alt_sel_q <= REG_WDATA; // [R20]
            if (wr_hit(REG_ADDR, `SACL_ADDR_CTL))
            begin
                pin_mode_q <= REG_WDATA[`SACL_CTL_PIN_MODE]; // [R2]
                sel_q <= REG_WDATA[`SACL_CTL_SEL];
                auto_rx_q <= REG_WDATA[`SACL_CTL_AUTO_RX];
            end
            if (wr_hit(REG_ADDR, `SACL_ADDR_TX_LO))
                tx_lo_q <= REG_WDATA;
            if (wr_hit(REG_ADDR, `SACL_ADDR_TX_HI))
                tx_hi_q <= REG_WDATA[5:0];
            if (ev_rx_done)
            begin
                rx_lo_q <= {rx_shift_q[6:0], rx_bit}; // [R17]
                rx_hi_q <= rx_shift_q[8:7];
            end
            // error bit is per transaction: cleared when a new one starts
            if (ev_rx_err)
                rx_err_q <= 1'b1; // [R7]
            else if (st_q == ST_IDLE && st_d != ST_IDLE)
                rx_err_q <= 1'b0;
            if (wr_hit(REG_ADDR, `SACL_ADDR_MASK))
                mask_q <= REG_WDATA; // [R8]
            // set wins over a clear landing in the same cycle
            raw_q <= (raw_q & ~(wr_hit(REG_ADDR, `SACL_ADDR_CLR) ? REG_WDATA : 8'h00))
                     | ({2'b00, ev_rx_done, ev_tx_done, ev_timeout, 3'b000}); // [R4] [R5] [R6]
        end
    end

    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
            INTERRUPT_REQUEST_OUT <= 1'b0;
        else
            INTERRUPT_REQUEST_OUT <= |(raw_q & mask_q & `SACL_EV_ALL); // [R8]
    end

    // ==========================================================
    // read path
    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
            REG_RDATA <= `SACL_RST_BYTE;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                `SACL_ADDR_ALT_SEL: REG_RDATA <= alt_sel_q;
                `SACL_ADDR_CTL: REG_RDATA <= {2'b00, rx_err_q, auto_rx_q, (st_q != ST_IDLE), sel_q,
                                              1'b0, pin_mode_q};
                `SACL_ADDR_TX_LO: REG_RDATA <= tx_lo_q;
                `SACL_ADDR_TX_HI: REG_RDATA <= {2'b00, tx_hi_q};
                `SACL_ADDR_RX_LO: REG_RDATA <= rx_lo_q; // [R17]
                `SACL_ADDR_RX_HI: REG_RDATA <= {6'h00, rx_hi_q};
                `SACL_ADDR_RAW: REG_RDATA <= raw_q;
                `SACL_ADDR_STAT: REG_RDATA <= raw_q & mask_q;
                `SACL_ADDR_MASK: REG_RDATA <= mask_q;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

endmodule

// [test/sacl_antenna_model.sv]
`timescale 1ns/1ns
// ==========================================
// far-side antenna: decodes the sent word, answers with pulses
module sacl_antenna_model #(
    parameter integer SLICE_CYC = 4
) (
    // clock
    input wire clk,
    // line seen from the device
    input wire line_o,
    input wire line_oe_n,
    // reply control
    input wire rep_en,
    input wire [3:0] rep_bits,
    input wire [9:0] rep_word,
    // reply level and decoded word
    output reg rep_line,
    output reg [13:0] got_word
);
integer hi = 0;
integer i;
initial rep_line = 1'b0;
initial got_word = 14'h0000;
// negedge sampling avoids racing the device's own edge
always @(negedge clk)
begin
    if (!line_oe_n && line_o)
        hi = hi + 1;
    else if (hi > 0)
    begin
        got_word = {got_word[12:0], hi >= 2 * SLICE_CYC};
        hi = 0;
    end
end
// line idles low (pull-down), so an idle reply reads as no pulse
always @(posedge line_oe_n)
begin
    if (rep_en)
    begin
        repeat (20) @(posedge clk);
        for (i = 0; i < rep_bits; i = i + 1)
        begin
            #1 rep_line = 1'b1;
            repeat (rep_word[9 - i] ? 3 * SLICE_CYC : SLICE_CYC) @(posedge clk);
            #1 rep_line = 1'b0;
            repeat (rep_word[9 - i] ? SLICE_CYC : 3 * SLICE_CYC) @(posedge clk);
        end
    end
end
endmodule

// [test/sacl_top_monitor.sv]
`timescale 1ns/1ns
// ==========================================
// port checker
module sacl_top_monitor #(
    parameter integer SLICE_CYC = 4,
    parameter integer BIT_SLICES = 4
) (
    // clock and reset
    input wire REF_CLK,
    input wire RESETN,
    // register port
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    // antenna side
    input wire ANTENNA_LINE_IO_O,
    input wire ANTENNA_LINE_IO_OE_N,
    input wire ANTENNA_DIRECTION_OUT,
    input wire ANTENNA_DIRECTION_OUT_OE_N,
    input wire INTERRUPT_REQUEST_OUT
);
localparam integer WORD_CYC = 14 * BIT_SLICES * SLICE_CYC;
reg [31:0] low_q;
wire ctl_wr = REG_WR && REG_ADDR == 8'h5f;
always @(posedge REF_CLK or negedge RESETN)
begin
    if (!RESETN || ANTENNA_LINE_IO_OE_N)
        low_q <= 32'h0;
    else
        low_q <= low_q + 32'h1;
end
default clocking @(posedge REF_CLK); endclocking
default disable iff (!RESETN);
a_dir_while_send: assert property (!ANTENNA_LINE_IO_OE_N |-> ANTENNA_DIRECTION_OUT)
    else $error("direction low while sending");
a_dir_when_idle: assert property (ANTENNA_LINE_IO_OE_N |-> !ANTENNA_DIRECTION_OUT)
    else $error("direction high while line released");
a_go_starts_send: assert property (ctl_wr && REG_WDATA[3] && ANTENNA_LINE_IO_OE_N |-> ##[1:2] !ANTENNA_LINE_IO_OE_N)
    else $error("start write did not drive line");
a_send_starts_high: assert property ($fell(ANTENNA_LINE_IO_OE_N) |-> ANTENNA_LINE_IO_O)
    else $error("word does not open with high level");
a_word_length: assert property ($rose(ANTENNA_LINE_IO_OE_N) |-> low_q == WORD_CYC)
    else $error("sent word has wrong length");
a_mask_silences: assert property (REG_WR && REG_ADDR == 8'hfd && REG_WDATA == 8'h00 |-> ##2 !INTERRUPT_REQUEST_OUT)
    else $error("request stays up with all masked");
a_two_pin_dir: assert property (ctl_wr && REG_WDATA[0] |-> ##2 ANTENNA_DIRECTION_OUT_OE_N)
    else $error("direction pin driven in two-pin mode");
a_one_pin_dir: assert property (ctl_wr && REG_WDATA[4] && !REG_WDATA[0] |-> ##2 !ANTENNA_DIRECTION_OUT_OE_N)
    else $error("direction pin not driven in one-pin mode");
c_send_done: cover property ($rose(ANTENNA_LINE_IO_OE_N));
c_irq: cover property ($rose(INTERRUPT_REQUEST_OUT));
c_two_pin: cover property (ctl_wr && REG_WDATA[0]);
endmodule
bind sacl_top sacl_top_monitor #(.SLICE_CYC(SLICE_CYC), .BIT_SLICES(BIT_SLICES)) i_sacl_top_monitor (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .ANTENNA_LINE_IO_O(ANTENNA_LINE_IO_O), .ANTENNA_LINE_IO_OE_N(ANTENNA_LINE_IO_OE_N),
    .ANTENNA_DIRECTION_OUT(ANTENNA_DIRECTION_OUT), .ANTENNA_DIRECTION_OUT_OE_N(ANTENNA_DIRECTION_OUT_OE_N),
    .INTERRUPT_REQUEST_OUT(INTERRUPT_REQUEST_OUT));

// [test/test_smart_antenna_control_link.sv]
`timescale 1ns/1ns
module test_smart_antenna_control_link;
reg clk, rstn, wr_s, rd_s, rep_en, two_pin;
reg [7:0] addr, wdata, v, lo;
reg [3:0] rep_bits;
reg [9:0] rep_word;
integer error_cnt, total_checks, cyc, n;
wire [7:0] rdata;
wire o, oe_n, dir, dir_oe_n, irq, rep;
wire [13:0] got;
// released line: reply lands only on the selected pin
wire line_i = !oe_n ? o : (two_pin ? 1'b0 : rep);
wire sep_i = two_pin ? rep : 1'b0;
sacl_top #(.REPLY_CYC(200), .SLICE_CYC(4)) i_sacl_top (
    .REF_CLK(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_RDATA(rdata), .ANTENNA_LINE_IO_I(line_i), .ANTENNA_LINE_IO_O(o), .ANTENNA_LINE_IO_OE_N(oe_n),
    .ANTENNA_DIRECTION_OUT(dir), .ANTENNA_DIRECTION_OUT_OE_N(dir_oe_n), .ANTENNA_SEPARATE_INPUT(sep_i),
    .INTERRUPT_REQUEST_OUT(irq));
sacl_antenna_model #(.SLICE_CYC(4)) i_sacl_antenna_model (
    .clk(clk), .line_o(line_i), .line_oe_n(oe_n), .rep_en(rep_en), .rep_bits(rep_bits),
    .rep_word(rep_word), .rep_line(rep), .got_word(got));
// ==========================================
// helpers
task final_report;
begin
    if (error_cnt == 0 && total_checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask
task chk(input [15:0] seen, input [15:0] exp, input string nm);
begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
        error_cnt = error_cnt + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
end
endtask
task wr(input [7:0] a, input [7:0] d);
begin
    @(posedge clk) #1 addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(posedge clk) #1 wr_s = 1'b0;
end
endtask
task rd(input [7:0] a);
begin
    @(posedge clk) #1 addr = a;
    rd_s = 1'b1;
    @(posedge clk) #1 rd_s = 1'b0;
    v = rdata;
end
endtask
// a full reply gives rx done, anything else a timeout
function [7:0] exp_raw(input en, input [3:0] nb);
    exp_raw = (en && nb == 4'ha) ? 8'h30 : 8'h18;
endfunction
task xact(input [13:0] tw, input en, input [3:0] nb, input tp);
begin
    rep_en = en;
    rep_bits = nb;
    two_pin = tp;
    rep_word = 10'($urandom % 1023 + 1);
    wr(8'h4f, {7'h00, tp});
    wr(8'h60, tw[7:0]);
    wr(8'h61, {2'b00, tw[13:8]});
    wr(8'hff, 8'h38);
    wr(8'h5f, {7'h0e, tp});
    n = 0;
    v = 8'h00;
    while ((v & 8'h28) == 8'h00 && n < 400)
    begin
        rd(8'hf9);
        n = n + 1;
    end
    chk(v, exp_raw(en, nb), "raw flags");
    chk(irq, 1'b1, "irq");
    chk(got, tw, "line word");
    rd(8'h5f);
    chk(v[5], en && nb != 4'ha, "rx error");
    if (nb == 4'ha)
    begin
        rd(8'h62);
        lo = v;
        rd(8'h63);
        chk({v[1:0], lo}, rep_word, "rx word");
    end
end
endtask
// ==========================================
// stimulus
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
always @(posedge clk)
begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
        error_cnt = error_cnt + 1;
        final_report;
    end
end
initial
begin
    rstn = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    rep_en = 1'b0;
    two_pin = 1'b0;
    rep_bits = 4'h0;
    rep_word = 10'h000;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    void'($urandom(73));
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    chk(dir_oe_n, 1'b1, "dir enable");
    rd(8'h5f);
    chk(v, 8'h00, "ctl reset");
    wr(8'hfd, 8'h38);
    xact(14'h0000, 1'b0, 4'h0, 1'b0);
    xact(14'($urandom), 1'b1, 4'ha, 1'b0);
    xact(14'($urandom), 1'b1, 4'ha, 1'b1);
    xact(14'($urandom), 1'b1, 4'h4, 1'b0);
    repeat (3) xact(14'($urandom), 1'b1, 4'ha, 1'($urandom));
    wr(8'hfd, 8'h00);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0, "irq masked");
    rd(8'hfb);
    chk(v, 8'h00, "masked status");
    rd(8'hf9);
    chk(v, 8'h30, "polled raw");
    wr(8'hff, 8'h38);
    rd(8'hf9);
    chk(v, 8'h00, "raw cleared");
    // receive-only arm with a silent antenna: timeout alone, no send
    rep_en = 1'b0;
    wr(8'h5f, 8'h10);
    repeat (210) @(posedge clk);
    chk(oe_n, 1'b1, "line released");
    chk(dir, 1'b0, "dir receiving");
    rd(8'hf9);
    chk(v, 8'h08, "rx only timeout");
    rd(8'h5f);
    chk(v, 8'h10, "ctl after rx wait");
    final_report;
end
endmodule
